// file: test_test_pattern_table_sequencer.sv
// Self-checking bench for the pattern table sequencer
`timescale 1ns/1ns
module test_test_pattern_table_sequencer;
    logic ref_clk, rst_n, seqStart, seqEnd, relayCloseCmd, relayOpenCmd, imageLoadWe, sourceSelect, resultSelect;
    logic stepRef, flagReq, flagClear, loopStart, loopIterEnd, stepDone, stepFail, loopActive, loopDone, loopFail;
    logic seqRunning, resMode;
    logic [7:0] pinDeclared, relayPinSel, imageAddr, imageData, imageLast, resultReadAddr, resultReadData, stepOffset;
    logic [7:0] flagNum, sensePins, relayClosed, expectPattern, stepPointer, boardVal, ptr, cap;
    logic [7:0] mem [4];
    logic [1:0] stepDir;
    logic [15:0] loopCount;
    logic [255:0] failFlags;
    int fails = 0, samples_checked = 0, seed = 14, cyc = 0;
    tpts_sequencer i_dut (.ref_clk, .rst_n, .seqStart, .seqEnd, .pinDeclared, .relayCloseCmd, .relayOpenCmd,
        .relayPinSel, .imageLoadWe, .imageAddr, .imageData, .imageLast, .resultReadAddr, .resultReadData,
        .sourceSelect, .resultSelect, .stepOffset, .stepRef, .stepDir, .flagReq, .flagNum, .flagClear, .loopStart,
        .loopCount, .loopIterEnd, .sensePins, .relayClosed, .expectPattern, .stepPointer, .stepDone, .stepFail,
        .loopActive, .loopDone, .loopFail, .failFlags, .seqRunning);
    tpts_uut_model i_uut (.ref_clk, .relayClosed, .boardVal, .sensePins);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick;
        @(posedge ref_clk);
        {seqStart, seqEnd, relayCloseCmd, relayOpenCmd, imageLoadWe, sourceSelect, resultSelect} <= '0;
        {stepRef, flagReq, flagClear, loopStart, loopIterEnd} <= '0;
        #1;
    endtask : tick
    function automatic logic [7:0] ptr_next(input logic [7:0] p, input logic [1:0] d);
        if (d == 2'h1 && p < imageLast) return p + 8'h01;
        if (d == 2'h2 && p > 8'h00) return p - 8'h01;
        return p;
    endfunction : ptr_next
    task automatic step(input logic [1:0] dir, input logic bad);
        logic [7:0] val;
        logic       prev;
        logic       expF;
        val = resMode ? 8'($random(seed)) : mem[ptr] ^ (bad ? 8'($random(seed)) | 8'h10 : 8'h00);
        expF = bad && !resMode;
        @(posedge ref_clk);
        boardVal <= val;
        flagNum <= 8'($random(seed));
        @(posedge ref_clk);
        stepRef <= 1'b1;
        stepDir <= dir;
        flagReq <= 1'b1;
        prev = failFlags[flagNum];
        tick();
        cap = val;
        chk({7'h0, stepDone}, 8'h01);
        chk({7'h0, stepFail}, {7'h0, expF});
        chk({7'h0, failFlags[flagNum]}, {7'h0, prev | expF});
        if (!resMode) chk(expectPattern, mem[ptr]);
        ptr = ptr_next(ptr, dir);
        chk(stepPointer, ptr);
    endtask : step
    task automatic loop_run(input logic [15:0] n, input int bad);
        @(posedge ref_clk);
        loopStart <= 1'b1;
        loopCount <= n;
        tick();
        chk({7'h0, loopActive}, 8'h01);
        for (int k = 0; k < n; k++) begin
            if (n > 1) step(2'h0, k == bad);
            @(posedge ref_clk);
            loopIterEnd <= 1'b1;
            tick();
            chk({7'h0, loopDone}, {7'h0, k == n - 1});
        end
        chk({7'h0, loopActive}, 8'h00);
        chk({7'h0, loopFail}, {7'h0, bad < n});
    endtask : loop_run
    initial begin
        {rst_n, seqStart, seqEnd, relayCloseCmd, relayOpenCmd, imageLoadWe, sourceSelect, resultSelect} = '0;
        {stepRef, flagReq, flagClear, loopStart, loopIterEnd, resMode, stepDir, loopCount} = '0;
        {pinDeclared, relayPinSel, imageAddr, imageData, resultReadAddr, stepOffset, flagNum, boardVal, ptr} = '0;
        imageLast = 8'h03;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            mem[i] = 8'($random(seed));
            imageLoadWe <= 1'b1;
            imageAddr <= 8'(i);
            imageData <= mem[i];
            tick();
        end
        @(posedge ref_clk);
        pinDeclared <= 8'($random(seed));
        seqStart <= 1'b1;
        tick();
        chk(relayClosed, pinDeclared);
        chk({7'h0, seqRunning}, 8'h01);
        @(posedge ref_clk);
        relayOpenCmd <= 1'b1;
        relayPinSel <= 8'hF0;
        tick();
        chk(relayClosed, pinDeclared & 8'h0F);
        @(posedge ref_clk);
        relayCloseCmd <= 1'b1;
        relayPinSel <= 8'hFF;
        tick();
        chk(relayClosed, 8'hFF);
        @(posedge ref_clk);
        sourceSelect <= 1'b1;
        tick();
        chk(stepPointer, 8'h00);
        for (int i = 0; i < 5; i++) step(2'h1, i[0]);
        for (int i = 0; i < 5; i++) step(2'h2, !i[0]);
        @(posedge ref_clk);
        flagClear <= 1'b1;
        tick();
        chk({7'h0, |failFlags}, 8'h00);
        loop_run(16'h0002, 0);
        loop_run(16'h0001, 5);
        @(posedge ref_clk);
        resultSelect <= 1'b1;
        stepOffset <= 8'h02;
        tick();
        ptr = 8'h02;
        resMode = 1'b1;
        chk(stepPointer, 8'h02);
        step(2'h1, 1'b0);
        @(posedge ref_clk);
        resultReadAddr <= 8'h02;
        tick();
        chk(resultReadData, cap);
        @(posedge ref_clk);
        seqEnd <= 1'b1;
        tick();
        chk(relayClosed, 8'h00);
        chk({7'h0, seqRunning}, 8'h00);
        end_sim();
    end
endmodule : test_test_pattern_table_sequencer
bind tpts_sequencer tpts_checker i_chk (.ref_clk, .rst_n, .seqStart, .seqEnd, .pinDeclared, .relayCloseCmd,
    .relayOpenCmd, .relayPinSel, .imageLast, .sourceSelect, .resultSelect, .stepOffset, .stepRef, .stepDir,
    .loopStart, .loopCount, .loopIterEnd, .loopActive, .loopDone, .relayClosed, .stepPointer, .stepDone, .seqRunning);

// file: tpts_checker.sv
// Port assertions for the pattern table sequencer
`timescale 1ns/1ns
module tpts_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        seqStart,
    input wire logic        seqEnd,
    input wire logic [7:0]  pinDeclared,
    input wire logic        relayCloseCmd,
    input wire logic        relayOpenCmd,
    input wire logic [7:0]  relayPinSel,
    input wire logic [7:0]  imageLast,
    input wire logic        sourceSelect,
    input wire logic        resultSelect,
    input wire logic [7:0]  stepOffset,
    input wire logic        stepRef,
    input wire logic [1:0]  stepDir,
    input wire logic        loopStart,
    input wire logic [15:0] loopCount,
    input wire logic        loopIterEnd,
    input wire logic        loopActive,
    input wire logic        loopDone,
    input wire logic [7:0]  relayClosed,
    input wire logic [7:0]  stepPointer,
    input wire logic        stepDone,
    input wire logic        seqRunning
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_seq_go;
        seqStart && !seqRunning && !$past(seqRunning);
    endsequence
    sequence s_one_iter;
        loopStart && !loopActive && loopCount == 16'h0001 ##1 !loopStart && !loopIterEnd
            ##1 loopIterEnd && !loopStart;
    endsequence
    a_step_done: assert property (stepDone == $past(stepRef)) else $error("step done wrong");
    a_ptr_inc: assert property (stepRef && stepDir == 2'h1 && !sourceSelect && !resultSelect |=> stepPointer ==
        ($past(stepPointer) < $past(imageLast) ? $past(stepPointer) + 8'h01 : $past(stepPointer)))
        else $error("increment wrong");
    a_ptr_dec: assert property (stepRef && stepDir == 2'h2 && !sourceSelect && !resultSelect |=> stepPointer ==
        ($past(stepPointer) > 8'h00 ? $past(stepPointer) - 8'h01 : $past(stepPointer)))
        else $error("decrement wrong");
    a_src_first: assert property (sourceSelect && !resultSelect |=> stepPointer == 8'h00) else $error("source ptr");
    a_res_offset: assert property (resultSelect |=> stepPointer == $past(stepOffset)) else $error("result ptr");
    a_seq_close: assert property (s_seq_go |=> seqRunning && relayClosed == $past(pinDeclared))
        else $error("start relays");
    a_seq_open: assert property (seqRunning && seqEnd |=> relayClosed == 8'h00) else $error("end relays");
    a_relay_close: assert property (seqRunning && relayCloseCmd && !seqEnd |=>
        relayClosed == ($past(relayClosed) | $past(relayPinSel))) else $error("close relays");
    a_relay_open: assert property (seqRunning && relayOpenCmd && !relayCloseCmd && !seqEnd |=>
        relayClosed == ($past(relayClosed) & ~$past(relayPinSel))) else $error("open relays");
    a_loop_full: assert property (s_one_iter |=> loopDone) else $error("loop end");
endmodule : tpts_checker

// file: tpts_pkg.sv
// Shared constants and types for the test pattern table sequencer
package tpts_pkg;
    localparam int STEP_W      = 8;
    localparam int PTR_W       = 8;
    localparam int PIN_N       = 8;
    localparam int CNT_W       = 16;
    localparam int FLAG_W      = 8;
    localparam int FLAG_N      = 256;
    localparam logic [PTR_W-1:0]  PTR_FIRST = 8'h00;
    localparam logic [PIN_N-1:0]  RELAY_OPEN_ALL = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        TPTS_STEP_HOLD = 2'h0,
        TPTS_STEP_INC  = 2'h1,
        TPTS_STEP_DEC  = 2'h2
    } tpts_step_e;

    typedef enum logic [2:0] {
        TPTS_IDLE = 3'h1,
        TPTS_RUN  = 3'h2,
        TPTS_DONE = 3'h4
    } tpts_state_e;
endpackage : tpts_pkg

// file: tpts_sequencer.sv
// Pattern table sequencer: relays, table steps, capture and unconditional loop
`timescale 1ns/1ns
module tpts_sequencer #(
    parameter int PIN_N = tpts_pkg::PIN_N,
    parameter int PTR_W = tpts_pkg::PTR_W,
    parameter int CNT_W = tpts_pkg::CNT_W
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      seqStart,
    input  wire logic                      seqEnd,
    input  wire logic [PIN_N-1:0]          pinDeclared,
    input  wire logic                      relayCloseCmd,
    input  wire logic                      relayOpenCmd,
    input  wire logic [PIN_N-1:0]          relayPinSel,
    input  wire logic                      imageLoadWe,
    input  wire logic [PTR_W-1:0]          imageAddr,
    input  wire logic [PIN_N-1:0]          imageData,
    input  wire logic [PTR_W-1:0]          imageLast,
    input  wire logic [PTR_W-1:0]          resultReadAddr,
    output logic      [PIN_N-1:0]          resultReadData,
    input  wire logic                      sourceSelect,
    input  wire logic                      resultSelect,
    input  wire logic [PTR_W-1:0]          stepOffset,
    input  wire logic                      stepRef,
    input  wire logic [1:0]                stepDir,
    input  wire logic                      flagReq,
    input  wire logic [tpts_pkg::FLAG_W-1:0] flagNum,
    input  wire logic                      flagClear,
    input  wire logic                      loopStart,
    input  wire logic [CNT_W-1:0]          loopCount,
    input  wire logic                      loopIterEnd,
    input  wire logic [PIN_N-1:0]          sensePins,
    output logic      [PIN_N-1:0]          relayClosed,
    output logic      [PIN_N-1:0]          expectPattern,
    output logic      [PTR_W-1:0]          stepPointer,
    output logic                           stepDone,
    output logic                           stepFail,
    output logic                           loopActive,
    output logic                           loopDone,
    output logic                           loopFail,
    output logic      [tpts_pkg::FLAG_N-1:0] failFlags,
    output logic                           seqRunning
);
    localparam int DEPTH = 1 << PTR_W;

    // Bit PIN_N-1 holds the first pin of the table's list
    logic [PIN_N-1:0] patMem [DEPTH];
    logic [PIN_N-1:0] resMem [DEPTH];

    tpts_pkg::tpts_state_e state_r, state_nxt;
    logic [PIN_N-1:0] relay_r, relay_nxt;
    logic             resMode_r, resMode_nxt;
    logic [PIN_N-1:0] expect_r, expect_nxt;
    logic             done_r, done_nxt;
    logic             fail_r, fail_nxt;
    logic [CNT_W-1:0] loopCnt_r, loopCnt_nxt;
    logic             loopAcc_r, loopAcc_nxt;
    logic             loopDone_r, loopDone_nxt;
    logic             loopFail_r, loopFail_nxt;
    logic [tpts_pkg::FLAG_N-1:0] flags_r, flags_nxt;
    logic [PIN_N-1:0] rdData_r;
    logic [PIN_N-1:0] stepData;
    logic             mismatch;
    logic             ptrLoad;
    logic [PTR_W-1:0] ptrLoadVal;
    logic [PTR_W-1:0] ptrNow;
    logic             patFail;
    logic             loopLast;

    function automatic logic pattern_fail(input logic resMode, input logic miss);
        return !resMode && miss;
    endfunction : pattern_fail

    assign ptrLoad    = sourceSelect | resultSelect;
    assign ptrLoadVal = resultSelect ? stepOffset : PTR_W'(tpts_pkg::PTR_FIRST);

    tpts_step_ptr #(.PTR_W(PTR_W)) u_ptr (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .load     (ptrLoad),
        .loadVal  (ptrLoadVal),
        .advance  (stepRef),
        .dir      (stepDir),
        .lastStep (imageLast),
        .stepPtr  (ptrNow)
    );

    assign stepData = patMem[ptrNow];
    // Expected one needs high, zero needs low
    assign mismatch = |(stepData ^ sensePins);
    assign patFail  = pattern_fail(resMode_r, mismatch);
    assign loopLast = (loopCnt_r == CNT_W'(16'h0001));

    always_ff @(posedge ref_clk) begin
        if (imageLoadWe) patMem[imageAddr] <= imageData;
        if (stepRef && resMode_r) resMem[ptrNow] <= sensePins;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) rdData_r <= '0;
        else rdData_r <= resMem[resultReadAddr];
    end

    always_comb begin
        state_nxt    = state_r;
        relay_nxt    = relay_r;
        resMode_nxt  = resMode_r;
        expect_nxt   = expect_r;
        done_nxt     = 1'b0;
        fail_nxt     = fail_r;
        loopCnt_nxt  = loopCnt_r;
        loopAcc_nxt  = loopAcc_r;
        loopDone_nxt = 1'b0;
        loopFail_nxt = loopFail_r;
        flags_nxt    = flags_r;
        case (state_r)
            tpts_pkg::TPTS_IDLE: begin
                if (seqStart) begin
                    relay_nxt = pinDeclared;
                    state_nxt = tpts_pkg::TPTS_RUN;
                end
            end
            tpts_pkg::TPTS_RUN: begin
                if (relayCloseCmd) relay_nxt = relay_r | relayPinSel;
                else if (relayOpenCmd) relay_nxt = relay_r & ~relayPinSel;
                if (seqEnd) begin
                    relay_nxt = PIN_N'(tpts_pkg::RELAY_OPEN_ALL);
                    state_nxt = tpts_pkg::TPTS_DONE;
                end
            end
            tpts_pkg::TPTS_DONE: begin
                state_nxt = tpts_pkg::TPTS_IDLE;
            end
            default: state_nxt = tpts_pkg::TPTS_IDLE;
        endcase
        if (sourceSelect) resMode_nxt = 1'b0;
        if (resultSelect) resMode_nxt = 1'b1;
        if (flagClear) flags_nxt = '0;
        if (stepRef) begin
            done_nxt   = 1'b1;
            expect_nxt = stepData;
            fail_nxt   = patFail;
            if (patFail && flagReq) flags_nxt[flagNum] = 1'b1;
        end
        if (loopStart) begin
            loopCnt_nxt = loopCount;
            loopAcc_nxt = 1'b0;
        end else if (loopCnt_r != CNT_W'(tpts_pkg::CNT_ZERO)) begin
            if (stepRef && patFail) loopAcc_nxt = 1'b1;
            if (loopIterEnd) begin
                loopCnt_nxt = CNT_W'(loopCnt_r - 1'b1);
                if (loopLast) begin
                    loopDone_nxt = 1'b1;
                    loopFail_nxt = loopAcc_nxt;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= tpts_pkg::TPTS_IDLE;
            relay_r    <= PIN_N'(tpts_pkg::RELAY_OPEN_ALL);
            resMode_r  <= 1'b0;
            expect_r   <= '0;
            done_r     <= 1'b0;
            fail_r     <= 1'b0;
            loopCnt_r  <= CNT_W'(tpts_pkg::CNT_ZERO);
            loopAcc_r  <= 1'b0;
            loopDone_r <= 1'b0;
            loopFail_r <= 1'b0;
            flags_r    <= '0;
        end else begin
            state_r    <= state_nxt;
            relay_r    <= relay_nxt;
            resMode_r  <= resMode_nxt;
            expect_r   <= expect_nxt;
            done_r     <= done_nxt;
            fail_r     <= fail_nxt;
            loopCnt_r  <= loopCnt_nxt;
            loopAcc_r  <= loopAcc_nxt;
            loopDone_r <= loopDone_nxt;
            loopFail_r <= loopFail_nxt;
            flags_r    <= flags_nxt;
        end
    end

    assign relayClosed    = relay_r;
    assign expectPattern  = expect_r;
    assign stepPointer    = ptrNow;
    assign stepDone       = done_r;
    assign stepFail       = fail_r;
    assign loopActive     = (loopCnt_r != CNT_W'(tpts_pkg::CNT_ZERO));
    assign loopDone       = loopDone_r;
    assign loopFail       = loopFail_r;
    assign failFlags      = flags_r;
    assign seqRunning     = (state_r == tpts_pkg::TPTS_RUN);
    assign resultReadData = rdData_r;
endmodule : tpts_sequencer

// file: tpts_step_ptr.sv
// Saturating step pointer for one pattern table
`timescale 1ns/1ns
module tpts_step_ptr #(
    parameter int PTR_W = tpts_pkg::PTR_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [PTR_W-1:0] loadVal,
    input  wire logic             advance,
    input  wire logic [1:0]       dir,
    input  wire logic [PTR_W-1:0] lastStep,
    output logic      [PTR_W-1:0] stepPtr
);
    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;

    always_comb begin
        ptr_nxt = ptr_r;
        if (load) begin
            ptr_nxt = loadVal;
        end else if (advance) begin
            case (dir)
                tpts_pkg::TPTS_STEP_INC: begin
                    if (ptr_r < lastStep) ptr_nxt = PTR_W'(ptr_r + 1'b1);
                end
                tpts_pkg::TPTS_STEP_DEC: begin
                    if (ptr_r > tpts_pkg::PTR_FIRST) ptr_nxt = PTR_W'(ptr_r - 1'b1);
                end
                default: ptr_nxt = ptr_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) ptr_r <= PTR_W'(tpts_pkg::PTR_FIRST);
        else ptr_r <= ptr_nxt;
    end

    assign stepPtr = ptr_r;
endmodule : tpts_step_ptr

// file: tpts_uut_model.sv
// Board under test seen through the nails
`timescale 1ns/1ns
module tpts_uut_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] relayClosed,
    input  wire logic [7:0] boardVal,
    output logic      [7:0] sensePins
);
    logic [7:0] float_r = 8'h5A;
    always @(posedge ref_clk) float_r <= ~float_r;
    // Open nails float with a changing pattern
    assign sensePins = (boardVal & relayClosed) | (float_r & ~relayClosed);
endmodule : tpts_uut_model
